//--- design/led_cmd_port_defs.vh
// constants for the serial command port of the two-channel led driver
`ifndef LED_CMD_PORT_DEFS_VH
`define LED_CMD_PORT_DEFS_VH

// register byte offsets on the axi4-lite slave
`define REG_STATUS        8'h00
`define REG_IRQ_STATUS    8'h04
`define REG_IRQ_ENABLE    8'h08
`define REG_IRQ_CLEAR     8'h0C
`define REG_LAST_BITS     8'h10

// status register fields
`define ST_FREQ_LO        0
`define ST_FREQ_HI        1
`define ST_POWER_GOOD     2
`define ST_OVER_TEMP      3
`define ST_CH1_DISABLED   4
`define ST_PATTERN_VALID  5
`define ST_PATTERN_LO     8
`define ST_PATTERN_HI     11

// interrupt event bits, same layout in status, enable and clear
`define IRQ_WIDTH         5
`define IRQ_CMD_ACCEPTED  0
`define IRQ_CMD_REFUSED   1
`define IRQ_POWER_GOOD    2
`define IRQ_OVER_TEMP     3
`define IRQ_PATTERN_SET   4

// sixteen-bit command codes, first bit received is the msb
`define CMD_FREQ_RESUME   16'hF777
`define CMD_FREQ_DOWN20   16'hF111
`define CMD_FREQ_DOWN40   16'hF333
`define CMD_CH1_DISABLE   16'hF555

// switching frequency setting codes
`define FREQ_NOMINAL      2'h0
`define FREQ_DOWN20       2'h1
`define FREQ_DOWN40       2'h2

// reset values
`define FREQ_RST          2'h0
`define IRQ_ENABLE_RST    5'h00
`define LAST_BITS_RST     16'h0000

// axi responses
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif

//--- design/cmd_shift_decoder.v
// sixteen-bit serial shift register and command matcher
`timescale 1ns/10ps
`default_nettype none
`include "led_cmd_port_defs.vh"

module cmd_shift_decoder
(
  input  wire        aclk,
  input  wire        clear,
  input  wire        shift_en,
  input  wire        bit_in,
  output reg  [15:0] last_bits,
  output reg         hit_resume,
  output reg         hit_down20,
  output reg         hit_down40,
  output reg         hit_ch1_off
);

  wire [15:0] bits_next;

  // oldest bit walks toward the msb, so the first bit sent ends leftmost
  assign bits_next = {last_bits[14:0], bit_in};

  always @(posedge aclk)
  begin
    if (clear)
    begin
      last_bits   <= `LAST_BITS_RST;
      hit_resume  <= 1'b0;
      hit_down20  <= 1'b0;
      hit_down40  <= 1'b0;
      hit_ch1_off <= 1'b0;
    end
    else
    begin
      hit_resume  <= shift_en && (bits_next == `CMD_FREQ_RESUME);
      hit_down20  <= shift_en && (bits_next == `CMD_FREQ_DOWN20);
      hit_down40  <= shift_en && (bits_next == `CMD_FREQ_DOWN40);
      hit_ch1_off <= shift_en && (bits_next == `CMD_CH1_DISABLE);
      if (shift_en)
      begin
        last_bits <= bits_next;
      end
    end
  end

endmodule // cmd_shift_decoder

`default_nettype wire

//--- design/led_cmd_port.v
// serial command port of the led driver with axi4-lite status and interrupts
`timescale 1ns/10ps
`default_nettype none
`include "led_cmd_port_defs.vh"

module led_cmd_port
(
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // pins and analog indications
  input  wire        dim_channel1_clock,
  input  wire        serial_io_pin_i,
  output wire        serial_io_pin_o,
  output wire        serial_io_pin_oe,
  input  wire        enable_pin,
  input  wire        feedback_pin_pg,
  input  wire        temp_trip_hot,
  input  wire        temp_below_release,
  input  wire        thermal_shutdown,
  input  wire        fault_report_valid,
  input  wire [3:0]  fault_report_code,
  // outputs to the power stage
  output reg  [1:0]  switching_frequency,
  output reg         ch1_enabled,
  output reg         ch1_current_on,
  output wire        irq
);

  // two-flop synchronisers for the pin inputs; fault_report_valid and fault_report_code are used without one
  reg  [1:0] dim_sync_reg;
  reg        dim_prev_reg;
  reg  [1:0] sio_sync_reg;
  reg  [1:0] en_sync_reg;
  reg  [1:0] fb_sync_reg;
  reg  [1:0] hot_sync_reg;
  reg  [1:0] cool_sync_reg;
  reg  [1:0] sd_sync_reg;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dim_sync_reg  <= 2'h0;
      dim_prev_reg  <= 1'b0;
      sio_sync_reg  <= 2'h3;
      en_sync_reg   <= 2'h0;
      fb_sync_reg   <= 2'h0;
      hot_sync_reg  <= 2'h0;
      cool_sync_reg <= 2'h0;
      sd_sync_reg   <= 2'h0;
    end
    else
    begin
      dim_sync_reg  <= {dim_sync_reg[0], dim_channel1_clock};
      dim_prev_reg  <= dim_sync_reg[1];
      sio_sync_reg  <= {sio_sync_reg[0], serial_io_pin_i};
      en_sync_reg   <= {en_sync_reg[0], enable_pin};
      fb_sync_reg   <= {fb_sync_reg[0], feedback_pin_pg};
      hot_sync_reg  <= {hot_sync_reg[0], temp_trip_hot};
      cool_sync_reg <= {cool_sync_reg[0], temp_below_release};
      sd_sync_reg   <= {sd_sync_reg[0], thermal_shutdown};
    end
  end

  wire dim_s   = dim_sync_reg[1];
  wire sio_s   = sio_sync_reg[1];
  wire en_s    = en_sync_reg[1];
  wire sd_s    = sd_sync_reg[1];
  // a steady dim level yields no edge and so no transfer
  wire dim_fall = dim_prev_reg & ~dim_s;

  // enable low acts like a reset of the command state
  wire func_rst = ~aresetn | ~en_s | sd_s;

  reg        pg_reg;
  reg        ot_reg;
  reg        pat_valid_reg;
  reg  [3:0] pat_code_reg;
  reg  [1:0] pat_ptr_reg;

  // power-good is held once reached, until the part is shut down
  always @(posedge aclk)
  begin
    if (func_rst)
    begin
      pg_reg <= 1'b0;
    end
    else if (fb_sync_reg[1])
    begin
      pg_reg <= 1'b1;
    end
  end

  // hysteresis between the trip and release comparators
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ot_reg <= 1'b0;
    end
    else if (hot_sync_reg[1])
    begin
      ot_reg <= 1'b1;
    end
    else if (cool_sync_reg[1])
    begin
      ot_reg <= 1'b0;
    end
  end

  // stored fault pattern, played out msb first, one bit per dim falling edge
  always @(posedge aclk)
  begin
    if (func_rst || ot_reg)
    begin
      pat_valid_reg <= 1'b0;
      pat_code_reg  <= 4'h0;
      pat_ptr_reg   <= 2'h0;
    end
    else
    begin
      if (fault_report_valid)
      begin
        pat_valid_reg <= 1'b1;
        pat_code_reg  <= fault_report_code;
        pat_ptr_reg   <= 2'h0;
      end
      else if (pat_valid_reg && dim_fall)
      begin
        pat_ptr_reg <= pat_ptr_reg + 2'h1;
      end
    end
  end

  wire pat_bit = pat_code_reg[2'h3 - pat_ptr_reg];

  // open drain: only ever drives low; over-temperature overrides the pattern
  assign serial_io_pin_o  = 1'b0;
  assign serial_io_pin_oe = ~pg_reg | ot_reg | (pat_valid_reg & ~pat_bit);

  // command receiver
  wire [15:0] last_bits;
  wire        hit_resume;
  wire        hit_down20;
  wire        hit_down40;
  wire        hit_ch1_off;

  cmd_shift_decoder u_decoder
  (
    .aclk        (aclk),
    .clear       (func_rst),
    .shift_en    (dim_fall),
    .bit_in      (sio_s),
    .last_bits   (last_bits),
    .hit_resume  (hit_resume),
    .hit_down20  (hit_down20),
    .hit_down40  (hit_down40),
    .hit_ch1_off (hit_ch1_off)
  );

  wire any_hit  = hit_resume | hit_down20 | hit_down40 | hit_ch1_off;
  wire accept   = pg_reg & ~ot_reg & ~pat_valid_reg;
  wire cmd_ok   = any_hit & accept;
  wire cmd_bad  = any_hit & ~accept;

  always @(posedge aclk)
  begin
    if (func_rst)
    begin
      switching_frequency <= `FREQ_RST;
      ch1_enabled         <= 1'b1;
    end
    else if (accept)
    begin
      if (hit_resume)
        switching_frequency <= `FREQ_NOMINAL;
      else if (hit_down20)
        switching_frequency <= `FREQ_DOWN20;
      else if (hit_down40)
        switching_frequency <= `FREQ_DOWN40;
      if (hit_ch1_off)
        ch1_enabled <= 1'b0;
    end
  end

  // once disabled, dim only clocks the serial pin and no longer gates current
  always @(posedge aclk)
  begin
    if (!aresetn)
      ch1_current_on <= 1'b0;
    else
      ch1_current_on <= dim_s & ch1_enabled & en_s;
  end

  // interrupt events
  reg                   pg_prev_reg;
  reg                   ot_prev_reg;
  reg                   pat_prev_reg;
  reg  [`IRQ_WIDTH-1:0] irq_status_reg;
  reg  [`IRQ_WIDTH-1:0] irq_enable_reg;
  wire [`IRQ_WIDTH-1:0] irq_event;
  wire [`IRQ_WIDTH-1:0] irq_clear;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pg_prev_reg  <= 1'b0;
      ot_prev_reg  <= 1'b0;
      pat_prev_reg <= 1'b0;
    end
    else
    begin
      pg_prev_reg  <= pg_reg;
      ot_prev_reg  <= ot_reg;
      pat_prev_reg <= pat_valid_reg;
    end
  end

  assign irq_event[`IRQ_CMD_ACCEPTED] = cmd_ok;
  assign irq_event[`IRQ_CMD_REFUSED]  = cmd_bad;
  assign irq_event[`IRQ_POWER_GOOD]   = pg_reg & ~pg_prev_reg;
  assign irq_event[`IRQ_OVER_TEMP]    = ot_reg & ~ot_prev_reg;
  assign irq_event[`IRQ_PATTERN_SET]  = pat_valid_reg & ~pat_prev_reg;

  // a new event in the cycle of its clear keeps the bit set
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1)
    begin : g_irq
      always @(posedge aclk)
      begin
        if (!aresetn)
          irq_status_reg[gi] <= 1'b0;
        else if (irq_event[gi])
          irq_status_reg[gi] <= 1'b1;
        else if (irq_clear[gi])
          irq_status_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  assign irq = |(irq_status_reg & irq_enable_reg);

  // axi4-lite write path: address and data may arrive in either order
  reg        aw_have_reg;
  reg  [7:0] aw_addr_reg;
  reg        w_have_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0] w_strb_reg;

  assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_reg & ~s_axi_bvalid;

  wire do_write  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire wr_enable = do_write & (aw_addr_reg[7:2] == `REG_IRQ_ENABLE >> 2);
  wire wr_clear  = do_write & (aw_addr_reg[7:2] == `REG_IRQ_CLEAR >> 2);
  wire wr_mapped = (aw_addr_reg[7:2] == `REG_STATUS >> 2)
                 | (aw_addr_reg[7:2] == `REG_IRQ_STATUS >> 2)
                 | (aw_addr_reg[7:2] == `REG_IRQ_ENABLE >> 2)
                 | (aw_addr_reg[7:2] == `REG_IRQ_CLEAR >> 2)
                 | (aw_addr_reg[7:2] == `REG_LAST_BITS >> 2);

  assign irq_clear = (wr_clear & w_strb_reg[0]) ? w_data_reg[`IRQ_WIDTH-1:0]
                                                : {`IRQ_WIDTH{1'b0}};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg    <= 1'b0;
      aw_addr_reg    <= 8'h00;
      w_have_reg     <= 1'b0;
      w_data_reg     <= 32'h00000000;
      w_strb_reg     <= 4'h0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `RESP_OKAY;
      irq_enable_reg <= `IRQ_ENABLE_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_enable && w_strb_reg[0])
      begin
        irq_enable_reg <= w_data_reg[`IRQ_WIDTH-1:0];
      end
    end
  end

  // axi4-lite read path, one cycle from address to data
  reg [31:0] status_word;

  always @*
  begin
    status_word = 32'h00000000;
    status_word[`ST_FREQ_HI:`ST_FREQ_LO]       = switching_frequency;
    status_word[`ST_POWER_GOOD]                = pg_reg;
    status_word[`ST_OVER_TEMP]                 = ot_reg;
    status_word[`ST_CH1_DISABLED]              = ~ch1_enabled;
    status_word[`ST_PATTERN_VALID]             = pat_valid_reg;
    status_word[`ST_PATTERN_HI:`ST_PATTERN_LO] = pat_code_reg;
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      // write-only clear register reads as zero
      case (s_axi_araddr[7:2])
        `REG_STATUS >> 2:     s_axi_rdata <= status_word;
        `REG_IRQ_STATUS >> 2: s_axi_rdata <= {27'h0000000, irq_status_reg};
        `REG_IRQ_ENABLE >> 2: s_axi_rdata <= {27'h0000000, irq_enable_reg};
        `REG_IRQ_CLEAR >> 2:  s_axi_rdata <= 32'h00000000;
        `REG_LAST_BITS >> 2:  s_axi_rdata <= {16'h0000, last_bits};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // led_cmd_port

`default_nettype wire

//--- bench/led_cmd_port_sva.sv
// pin-level assertions for the led driver serial command port
`timescale 1ns/10ps
`default_nettype none
module led_cmd_port_sva
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       dim_channel1_clock,
  input wire logic       enable_pin,
  input wire logic       thermal_shutdown,
  input wire logic       temp_trip_hot,
  input wire logic       serial_io_pin_oe,
  input wire logic [1:0] switching_frequency,
  input wire logic       ch1_enabled,
  input wire logic       ch1_current_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since the raw dim pin fell, and since enable came back; both saturate
  logic       dim_q = 1'b1;
  logic [3:0] since_fall = 4'hF;
  logic [3:0] en_cnt = 4'h0;
  always @(posedge aclk)
  begin
    dim_q <= dim_channel1_clock;
    if (dim_q && !dim_channel1_clock) since_fall <= 4'h0;
    else if (since_fall != 4'hF) since_fall <= since_fall + 4'h1;
    if (!enable_pin || thermal_shutdown) en_cnt <= 4'h0;
    else if (en_cnt != 4'hF) en_cnt <= en_cnt + 4'h1;
  end
  a_reset_values: assert property ($rose(aresetn) |-> switching_frequency == 2'h0 && ch1_enabled)
    else $error("outputs not at reset values");
  a_pg_lost_low: assert property ((!enable_pin)[*5] |-> serial_io_pin_oe)
    else $error("pin released while disabled");
  a_hot_pulls_low: assert property (temp_trip_hot[*5] |-> serial_io_pin_oe)
    else $error("pin released while hot");
  a_freq_on_bit: assert property ($changed(switching_frequency) && en_cnt == 4'hF |-> since_fall <= 4'h8)
    else $error("frequency changed away from a bit edge");
  a_ch1_off_bit: assert property ($fell(ch1_enabled) |-> since_fall <= 4'h8)
    else $error("channel 1 disabled away from a bit edge");
  a_off_no_current: assert property (!ch1_enabled && !$past(ch1_enabled) |-> !ch1_current_on)
    else $error("current on while channel 1 disabled");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule // led_cmd_port_sva
`default_nettype wire

//--- bench/serial_host_model.sv
// microcontroller model: dim bit clock and open-drain data on the serial pin
`timescale 1ns/10ps
`default_nettype none
module serial_host_model
(
  output var logic dim_channel1_clock,
  output var logic host_pull_low
);
  // dim idles high between words; the pin is released to the pull-up
  initial
  begin
    dim_channel1_clock = 1'b1;
    host_pull_low = 1'b0;
  end
  task send_word(input logic [15:0] word);
    integer i;
    begin
      // odd offset keeps dim edges off the block clock edges
      #37;
      for (i = 15; i >= 0; i = i - 1)
      begin
        host_pull_low = ~word[i];
        #400 dim_channel1_clock = 1'b0;
        #400 dim_channel1_clock = 1'b1;
      end
      host_pull_low = 1'b0;
    end
  endtask
endmodule // serial_host_model
`default_nettype wire

//--- bench/led_cmd_port_tb.sv
// self-checking bench for the led driver serial command port
`timescale 1ns/10ps
`default_nettype none
`include "led_cmd_port_defs.vh"
module led_cmd_port_tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, en = 1'b1, fb_pg = 1'b0, hot = 1'b0, cool = 1'b1;
  logic f_vld = 1'b0;
  logic [3:0] f_code = 4'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, freq;
  logic awready, wready, bvalid, arready, rvalid, irq, pin_oe, pin_o, ch1_en, ch1_cur;
  wire dim, host_low;
  // wire-and of pull-up, device and host
  wire pin_i = ~pin_oe & ~host_low;
  integer err_total = 0, n_compared = 0, i;
  localparam [47:0] codes = {`CMD_FREQ_DOWN20, `CMD_FREQ_DOWN40, `CMD_FREQ_RESUME};
  localparam [5:0] fexp = {`FREQ_DOWN20, `FREQ_DOWN40, `FREQ_NOMINAL};
  always #50 aclk = ~aclk;
  led_cmd_port dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dim_channel1_clock(dim), .serial_io_pin_i(pin_i), .serial_io_pin_o(pin_o),
    .serial_io_pin_oe(pin_oe), .enable_pin(en), .feedback_pin_pg(fb_pg),
    .temp_trip_hot(hot), .temp_below_release(cool), .thermal_shutdown(1'b0),
    .fault_report_valid(f_vld), .fault_report_code(f_code), .switching_frequency(freq),
    .ch1_enabled(ch1_en), .ch1_current_on(ch1_cur), .irq(irq)
  );
  serial_host_model host (.dim_channel1_clock(dim), .host_pull_low(host_low));
  task chk(input logic ok, input logic [63:0] m);
    begin
      n_compared = n_compared + 1;
      if (!ok)
      begin
        err_total = err_total + 1;
        $display("BAD %0t %0s", $time, m);
      end
    end
  endtask
  // one axi4-lite cycle: w=1 write d, w=0 read and compare against d
  task axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    begin
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      // no cycle limit here: only the watchdog ends a wait for the answer
      do
      begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (arready) arvalid <= 1'b0;
      end
      while (!(w ? bvalid : rvalid));
      bready <= 1'b0;
      rready <= 1'b0;
      chk(w ? bresp === r : rdata === d && rresp === r, "axi");
    end
  endtask
  task wait_cyc(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    wait_cyc(4);
    chk(freq === 2'h0 && ch1_en === 1'b1 && pin_oe === 1'b1 && pin_o === 1'b0, "reset");
    aresetn <= 1'b1;
    axi(0, `REG_IRQ_ENABLE, 32'h0, `RESP_OKAY);
    axi(0, 8'h20, 32'h0, `RESP_DECERR);
    axi(1, 8'h20, 32'h1F, `RESP_DECERR);
    axi(1, `REG_IRQ_ENABLE, 32'h1F, `RESP_OKAY);
    // before power-good the device holds the pin low, so only zeros arrive
    host.send_word(`CMD_FREQ_DOWN20);
    wait_cyc(8);
    chk(freq === `FREQ_NOMINAL, "no pg");
    axi(0, `REG_LAST_BITS, 32'h0, `RESP_OKAY);
    fb_pg <= 1'b1;
    wait_cyc(6);
    chk(pin_oe === 1'b0, "pg pin");
    axi(0, `REG_IRQ_STATUS, 32'h4, `RESP_OKAY);
    chk(irq === 1'b1, "irq set");
    axi(1, `REG_IRQ_CLEAR, 32'h1F, `RESP_OKAY);
    chk(irq === 1'b0, "irq clr");
    for (i = 0; i < 3; i = i + 1)
    begin
      host.send_word(codes[47-16*i -: 16]);
      wait_cyc(8);
      chk(freq === fexp[5-2*i -: 2], "freq");
    end
    axi(0, `REG_LAST_BITS, {16'h0, `CMD_FREQ_RESUME}, `RESP_OKAY);
    axi(1, `REG_IRQ_ENABLE, 32'h1E, `RESP_OKAY);
    chk(irq === 1'b0, "irq mask");
    axi(1, `REG_IRQ_CLEAR, 32'h1F, `RESP_OKAY);
    hot <= 1'b1;
    cool <= 1'b0;
    wait_cyc(6);
    hot <= 1'b0;
    chk(pin_oe === 1'b1, "hot pin");
    host.send_word(`CMD_FREQ_DOWN40);
    wait_cyc(8);
    chk(freq === `FREQ_NOMINAL, "hot cmd");
    cool <= 1'b1;
    wait_cyc(6);
    chk(pin_oe === 1'b0, "cool pin");
    // all-ones pattern never pulls the pin, so the code really arrives
    f_code <= 4'hF;
    f_vld <= 1'b1;
    wait_cyc(1);
    f_vld <= 1'b0;
    wait_cyc(4);
    axi(0, `REG_STATUS, 32'h0F24, `RESP_OKAY);
    host.send_word(`CMD_FREQ_DOWN40);
    wait_cyc(8);
    chk(freq === `FREQ_NOMINAL, "pat cmd");
    en <= 1'b0;
    wait_cyc(6);
    en <= 1'b1;
    wait_cyc(20);
    axi(0, `REG_STATUS, 32'h4, `RESP_OKAY);
    axi(0, `REG_IRQ_STATUS, 32'h1E, `RESP_OKAY);
    chk(ch1_cur === 1'b1, "ch1 on");
    host.send_word(`CMD_CH1_DISABLE);
    wait_cyc(8);
    chk(ch1_en === 1'b0 && ch1_cur === 1'b0, "ch1 off");
    host.send_word(`CMD_FREQ_DOWN20);
    wait_cyc(8);
    chk(freq === `FREQ_DOWN20, "dim clk");
    aresetn <= 1'b0;
    wait_cyc(4);
    aresetn <= 1'b1;
    wait_cyc(1);
    chk(ch1_en === 1'b1 && freq === `FREQ_NOMINAL, "rst2");
    summarize;
  end
  initial
  begin
    #2000000;
    err_total = err_total + 1;
    summarize;
  end
endmodule // led_cmd_port_tb
bind led_cmd_port led_cmd_port_sva chk_i (.*);
`default_nettype wire
